// ### rtl/brg_map.svh
// register offsets, reset values and bus address slots of the regulator bank
`ifndef BRG_MAP_SVH
`define BRG_MAP_SVH
// register offsets
`define BRG_OFS_EVENT 8'h00
`define BRG_OFS_LIVE 8'h01
`define BRG_OFS_GAP_A 8'h02
`define BRG_OFS_PRODUCT 8'h03
`define BRG_OFS_REVISION 8'h04
`define BRG_OFS_FEATURE 8'h05
`define BRG_OFS_PWR_OK 8'h12
`define BRG_OFS_TIMING 8'h13
`define BRG_OFS_COMMAND 8'h14
`define BRG_OFS_GAP_B 8'h15
`define BRG_OFS_LIMIT 8'h16
`define BRG_OFS_VOUT_HIGH 8'h17
`define BRG_OFS_VOUT_LOW 8'h18
// reset values
`define BRG_RST_EVENT 8'h00
`define BRG_RST_LIVE 8'h01
`define BRG_RST_FEATURE 8'h00
`define BRG_RST_PWR_OK 8'h11
`define BRG_RST_TIMING 8'h19
`define BRG_RST_COMMAND 8'h8d
`define BRG_RST_LIMIT 8'he3
`define BRG_RST_VOUT_HIGH 8'h28
`define BRG_RST_VOUT_LOW 8'h60
// live status bit that is always zero
`define BRG_SPARE_MASK 8'hef
// eight factory bus addresses, slot 7 first
`define BRG_ADDR_TABLE {7'h6c, 7'h68, 7'h64, 7'h60, 7'h1c, 7'h18, 7'h14, 7'h10}
// bits in one bus byte
`define BRG_BYTE_BITS 4'h8
`endif

// ### rtl/brg_pkg.sv
// types shared by the regulator register bank
package brg_pkg;
	// serial slave states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WRITE,
		ST_WRITE_ACK,
		ST_READ,
		ST_READ_ACK
	} brg_state_e;
	// one register byte
	typedef logic [7:0] brg_byte_t;
endpackage : brg_pkg

// ### rtl/brg_regbank.sv
// two-wire slave and register bank of a configurable step-down regulator
`timescale 1ns/1ps
`default_nettype none
`include "brg_map.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - read-only ignores writes, read-clear, read-write stores
// - reserved addresses have no register behind
// - event latch at 00h, live status 01h
// - power-ok/discharge setting at 12h
// - enable and ramp timing at 13h
// - operating command register at 14h
// - limit and reset config at 16h
// - pin selects 17h high, 18h low
// - write: pointer byte, then auto-incremented data
// - reads start at pointer, auto-increment
// - answer one of eight factory addresses
////////////////////////////////////////////////////////////////////////////////
module brg_regbank
	import brg_pkg::*;
#(
	parameter logic [2:0] ADDR_SEL = 3'h1, // factory address slot
	parameter logic [7:0] PRODUCT_CODE = 8'h5a, // arbitrary value
	parameter logic [7:0] REVISION_CODE = 8'h01, // arbitrary value
	parameter logic [7:0] FEATURE_CODE = `BRG_RST_FEATURE, // trim value
	// reset values of the six writable registers, highest offset first
	parameter logic [47:0] RW_RESET = {`BRG_RST_VOUT_LOW, `BRG_RST_VOUT_HIGH,
		`BRG_RST_LIMIT, `BRG_RST_COMMAND, `BRG_RST_TIMING, `BRG_RST_PWR_OK}
) (
	input wire logic CLK_SYS_I,
	input wire logic RSTN_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	input wire logic VOLTAGE_SELECT_PIN_I,
	input wire logic [7:0] STATUS_I,
	output logic [7:0] PWR_OK_CFG_O,
	output logic [7:0] RAMP_TIMING_O,
	output logic [7:0] OP_COMMAND_O,
	output logic [7:0] LIMIT_CFG_O,
	output logic [7:0] VOUT_SETTING_O
);
	////////////////////////////////////////////////////////////////////////////
	// bus sampling and framing
	logic scl_q; // previous clock line
	logic sda_q; // previous data line
	brg_state_e state; // slave state
	logic [3:0] bit_cnt; // bits moved in this byte
	logic [7:0] shift; // byte being moved
	brg_byte_t ptr; // register pointer
	logic ptr_phase; // next written byte is the pointer
	logic rd_mode; // current transaction reads
	logic nack; // controller refused the last byte
	logic drive; // pull data line low
	logic [55:0] addr_table; // all factory addresses
	logic [6:0] dev_addr; // our address
	logic scl_rise, scl_fall, start_cond, stop_cond, byte_done;
	logic load_rd, wr_en;
	brg_byte_t rd_data; // byte at the pointer

	// edge history; inputs already arrive synchronous
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= SCL_I;
			sda_q <= SDA_I;
		end
	end

	assign scl_rise = SCL_I & ~scl_q;
	assign scl_fall = ~SCL_I & scl_q;
	// data moving while the clock is high frames a transaction
	assign start_cond = scl_q & SCL_I & sda_q & ~SDA_I;
	assign stop_cond = scl_q & SCL_I & ~sda_q & SDA_I;
	assign byte_done = scl_fall & (bit_cnt == `BRG_BYTE_BITS);
	assign addr_table = `BRG_ADDR_TABLE;
	assign dev_addr = addr_table[ADDR_SEL*7 +: 7];
	// a read byte is fetched on the fall that ends an acked slot
	assign load_rd = scl_fall & (((state == ST_ADDR_ACK) & rd_mode) |
		((state == ST_READ_ACK) & ~nack));
	// every byte after the pointer byte is data
	assign wr_en = byte_done & (state == ST_WRITE) & ~ptr_phase;
	// open drain: only ever pull low
	assign SDA_O = 1'b0;
	assign SDA_OE_O = drive;

	////////////////////////////////////////////////////////////////////////////
	// slave state machine
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			ptr <= 8'h00;
			ptr_phase <= 1'b0;
			rd_mode <= 1'b0;
			nack <= 1'b0;
			drive <= 1'b0;
		end else if (start_cond) begin
			// repeated start keeps the pointer for the read
			state <= ST_ADDR;
			bit_cnt <= 4'h0;
			ptr_phase <= 1'b1;
			drive <= 1'b0;
		end else if (stop_cond) begin
			state <= ST_IDLE;
			drive <= 1'b0;
		end else begin
			case (state)
				ST_ADDR, ST_WRITE: begin
					// shift in on rising clock
					if (scl_rise) begin
						shift <= {shift[6:0], SDA_I};
						bit_cnt <= bit_cnt + 4'h1;
					end
					if (byte_done && state == ST_ADDR) begin
						if (shift[7:1] == dev_addr) begin
							state <= ST_ADDR_ACK;
							rd_mode <= shift[0];
							drive <= 1'b1;
						end else begin
							// not ours: sit out until the next start
							state <= ST_IDLE;
						end
					end else if (byte_done) begin
						state <= ST_WRITE_ACK;
						drive <= 1'b1;
						ptr_phase <= 1'b0;
						if (ptr_phase) begin
							ptr <= shift;
						end else begin
							// reserved slots still advance the pointer
							ptr <= ptr + 8'h01;
						end
					end
				end
				ST_ADDR_ACK, ST_WRITE_ACK: begin
					// release ack on the falling clock
					if (load_rd) begin
						state <= ST_READ;
						drive <= ~rd_data[7];
						shift <= {rd_data[6:0], 1'b0};
						bit_cnt <= 4'h1;
						ptr <= ptr + 8'h01;
					end else if (scl_fall) begin
						state <= ST_WRITE;
						drive <= 1'b0;
						bit_cnt <= 4'h0;
					end
				end
				ST_READ: begin
					// drive next bit after each fall
					if (byte_done) begin
						state <= ST_READ_ACK;
						drive <= 1'b0;
					end else if (scl_fall) begin
						drive <= ~shift[7];
						shift <= {shift[6:0], 1'b0};
						bit_cnt <= bit_cnt + 4'h1;
					end
				end
				ST_READ_ACK: begin
					// controller acks low, nacks high
					if (scl_rise) begin
						nack <= SDA_I;
					end
					if (load_rd) begin
						state <= ST_READ;
						drive <= ~rd_data[7];
						shift <= {rd_data[6:0], 1'b0};
						bit_cnt <= 4'h1;
						ptr <= ptr + 8'h01;
					end else if (scl_fall) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
					drive <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// event latch and live status
	brg_byte_t live_status; // real-time sense copy
	brg_byte_t event_latch; // sticky edge events
	logic [7:0] ev_set; // edges seen this cycle
	logic ev_clear; // event byte fetched for reading
	logic [7:0] next_event;

	// both edges count, spare bit never moves
	assign ev_set = (live_status ^ STATUS_I) & `BRG_SPARE_MASK;
	assign ev_clear = load_rd & (ptr == `BRG_OFS_EVENT);
	// set wins over the clear so no edge is lost
	assign next_event = (ev_clear ? 8'h00 : event_latch) | ev_set;

	// status registers; writes never reach them
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			live_status <= `BRG_RST_LIVE;
			event_latch <= `BRG_RST_EVENT;
		end else begin
			live_status <= STATUS_I & `BRG_SPARE_MASK;
			event_latch <= next_event;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// writable registers, one generate entry each
	localparam logic [47:0] RW_OFS = {`BRG_OFS_VOUT_LOW, `BRG_OFS_VOUT_HIGH,
		`BRG_OFS_LIMIT, `BRG_OFS_COMMAND, `BRG_OFS_TIMING, `BRG_OFS_PWR_OK};
	logic [7:0] rw_q [6]; // stored settings
	logic [7:0] rd_chain [7]; // or-chain of read hits

	assign rd_chain[0] =
		((ptr == `BRG_OFS_EVENT) ? event_latch : 8'h00) |
		((ptr == `BRG_OFS_LIVE) ? live_status : 8'h00) |
		((ptr == `BRG_OFS_PRODUCT) ? PRODUCT_CODE : 8'h00) |
		((ptr == `BRG_OFS_REVISION) ? REVISION_CODE : 8'h00) |
		((ptr == `BRG_OFS_FEATURE) ? FEATURE_CODE : 8'h00);
	// unmatched offsets fall through as zero
	assign rd_data = rd_chain[6];

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_rw
			logic hit; // pointer on this entry
			assign hit = (ptr == RW_OFS[gi*8 +: 8]);
			assign rd_chain[gi+1] = rd_chain[gi] | (hit ? rw_q[gi] : 8'h00);
			// store whatever the controller writes
			always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
				if (!RSTN_I) begin
					rw_q[gi] <= RW_RESET[gi*8 +: 8];
				end else if (wr_en && hit) begin
					rw_q[gi] <= shift;
				end
			end
		end
	endgenerate

	// settings to the regulator core
	assign PWR_OK_CFG_O = rw_q[0];
	assign RAMP_TIMING_O = rw_q[1];
	assign OP_COMMAND_O = rw_q[2];
	assign LIMIT_CFG_O = rw_q[3];

	// pin picks the active setting, registered for a clean output
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			VOUT_SETTING_O <= RW_RESET[47:40];
		end else begin
			VOUT_SETTING_O <= VOLTAGE_SELECT_PIN_I ? rw_q[4] : rw_q[5];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	event_clear_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		ev_clear |=> event_latch == $past(ev_set))
		else $error("event latch not cleared on read");
	event_edge_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(STATUS_I[0] != live_status[0]) |=> event_latch[0] && live_status[0] == $past(STATUS_I[0]))
		else $error("status edge not latched");
	reserved_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(ptr == `BRG_OFS_GAP_A || ptr == `BRG_OFS_GAP_B || ptr > `BRG_OFS_VOUT_LOW ||
		(ptr > `BRG_OFS_FEATURE && ptr < `BRG_OFS_PWR_OK)) |-> rd_data == 8'h00)
		else $error("reserved address reads nonzero");
	pwr_ok_write_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(wr_en && ptr == `BRG_OFS_PWR_OK) |=> PWR_OK_CFG_O == $past(shift))
		else $error("power-ok write lost");
	timing_write_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(wr_en && ptr == `BRG_OFS_TIMING) |=> RAMP_TIMING_O == $past(shift))
		else $error("timing write lost");
	command_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		!(wr_en && ptr == `BRG_OFS_COMMAND) |=> $stable(OP_COMMAND_O))
		else $error("command changed without a write");
	limit_write_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(wr_en && ptr == `BRG_OFS_LIMIT) |=> LIMIT_CFG_O == $past(shift))
		else $error("limit write lost");
	vout_select_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(wr_en && ptr == `BRG_OFS_VOUT_HIGH) ##1 VOLTAGE_SELECT_PIN_I |=>
		VOUT_SETTING_O == $past(shift, 2))
		else $error("high-pin setting not selected");
	write_incr_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(wr_en && !start_cond && !stop_cond) |=> ptr == $past(ptr) + 8'h01)
		else $error("write pointer did not advance");
	read_incr_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(load_rd && !start_cond && !stop_cond) |=> ptr == $past(ptr) + 8'h01 && state == ST_READ)
		else $error("read pointer did not advance");
	addr_miss_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(byte_done && state == ST_ADDR && shift[7:1] != dev_addr && !start_cond && !stop_cond)
		|=> state == ST_IDLE && !SDA_OE_O)
		else $error("foreign address answered");
endmodule : brg_regbank
`default_nettype wire

// ### tb/brg_host.sv
// two-wire bus controller model facing the regulator bank
`timescale 1ns/1ps
`default_nettype none
module brg_host
	import brg_pkg::*;
(
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	// clock stands high and data is released between frames
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// wait whole system clocks; every change lands just after an edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	// start or repeated start: data falls while clock is high
	task automatic bus_start();
		tick(2);
		sda_oe_o <= 1'b0;
		tick(3);
		scl_o <= 1'b1;
		tick(4);
		sda_oe_o <= 1'b1;
		tick(4);
		scl_o <= 1'b0;
	endtask : bus_start
	// stop: data rises while clock is high
	task automatic bus_stop();
		tick(2);
		sda_oe_o <= 1'b1;
		tick(3);
		scl_o <= 1'b1;
		tick(4);
		sda_oe_o <= 1'b0;
		tick(4);
	endtask : bus_stop
	// one bit; data held 2 clocks past the fall, so no false start or stop
	task automatic bit_cycle(input logic pull, output logic seen);
		tick(2);
		sda_oe_o <= pull;
		tick(3);
		scl_o <= 1'b1;
		tick(2);
		seen = sda_i;
		tick(2);
		scl_o <= 1'b0;
	endtask : bit_cycle
	// byte out, msb first, then the device's ack bit (0 = ack)
	task automatic put_byte(input brg_byte_t b, output logic nak);
		for (int i = 7; i >= 0; i--) bit_cycle(~b[i], nak);
		bit_cycle(1'b0, nak);
	endtask : put_byte
	// byte in, then our ack, or nack on the last byte
	task automatic get_byte(output brg_byte_t b, input logic last);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(1'b0, s);
			b[i] = s;
		end
		bit_cycle(~last, s);
	endtask : get_byte
endmodule : brg_host
`default_nettype wire

// ### tb/tb.sv
// self-checking bench of the regulator register bank
`timescale 1ns/1ps
`default_nettype none
`include "brg_map.svh"
module tb;
	import brg_pkg::*;
	localparam logic [6:0] DEV = 7'h14; // default address slot 1
	logic clk, rstn, pin_sel, host_oe, scl, dut_sda, dut_oe;
	logic [7:0] status, pwr_ok, ramp, cmd, limit, vout;
	wire logic sda;
	brg_byte_t mem [256]; // expected register contents
	logic [31:0] seed;
	int fail_count = 0;
	int compares = 0;
	// pull-up: low when either party pulls
	assign sda = ~(host_oe | (dut_oe & ~dut_sda));
	brg_regbank brg_regbank_inst (.CLK_SYS_I(clk), .RSTN_I(rstn), .SCL_I(scl), .SDA_I(sda),
		.SDA_O(dut_sda), .SDA_OE_O(dut_oe), .VOLTAGE_SELECT_PIN_I(pin_sel), .STATUS_I(status),
		.PWR_OK_CFG_O(pwr_ok), .RAMP_TIMING_O(ramp), .OP_COMMAND_O(cmd),
		.LIMIT_CFG_O(limit), .VOUT_SETTING_O(vout));
	brg_host brg_host_inst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
	////////////////////////////////////////////////////////////////////////////////
	// 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// xorshift source, fixed seed
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// only these six offsets keep written data
	function automatic logic writable(input brg_byte_t a);
		return a inside {8'h12, 8'h13, 8'h14, 8'h16, 8'h17, 8'h18};
	endfunction : writable
	// byte compare
	task automatic chk(input string what, input brg_byte_t exp, input brg_byte_t got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// address byte; nak seen as 1
	task automatic addr(input logic [6:0] dev, input logic rw, input logic exp_nak);
		logic nak;
		brg_host_inst.put_byte({dev, rw}, nak);
		chk("address ack", {7'h0, exp_nak}, {7'h0, nak});
	endtask : addr
	// pointer then data; the model keeps only writable targets
	task automatic wr(input brg_byte_t ptr, input brg_byte_t data[$]);
		logic nak;
		brg_host_inst.bus_start();
		addr(DEV, 1'b0, 1'b0);
		brg_host_inst.put_byte(ptr, nak);
		foreach (data[i]) begin
			brg_host_inst.put_byte(data[i], nak);
			if (writable(8'(ptr + i))) mem[8'(ptr + i)] = data[i];
		end
		brg_host_inst.bus_stop();
	endtask : wr
	// pointer write, then repeated start or stop and start, then n bytes
	task automatic rd(input brg_byte_t ptr, input int n, input logic rep);
		logic nak;
		brg_byte_t b;
		brg_host_inst.bus_start();
		addr(DEV, 1'b0, 1'b0);
		brg_host_inst.put_byte(ptr, nak);
		if (!rep) brg_host_inst.bus_stop();
		brg_host_inst.bus_start();
		addr(DEV, 1'b1, 1'b0);
		for (int i = 0; i < n; i++) begin
			brg_host_inst.get_byte(b, i == n - 1);
			chk($sformatf("reg %h", 8'(ptr + i)), mem[8'(ptr + i)], b);
			if (8'(ptr + i) == 8'h00) mem[0] = 8'h00;
		end
		brg_host_inst.bus_stop();
	endtask : rd
	// setting outputs against the model
	task automatic ports();
		chk("pwr ok", mem[8'h12], pwr_ok);
		chk("ramp", mem[8'h13], ramp);
		chk("command", mem[8'h14], cmd);
		chk("limit", mem[8'h16], limit);
		chk("vout", pin_sel ? mem[8'h17] : mem[8'h18], vout);
	endtask : ports
	// verdict and end of run
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		brg_byte_t wq[$];
		brg_byte_t st;
		logic [6:0] foreign [3]; // addresses of other slots, one near miss
		rstn = 1'b0;
		pin_sel = 1'b0;
		status = 8'h01;
		seed = 32'h0001_124e;
		foreign = '{7'h10, 7'h15, 7'h6c};
		foreach (mem[i]) mem[i] = 8'h00;
		mem[8'h01] = `BRG_RST_LIVE;
		mem[8'h03] = 8'h5a;
		mem[8'h04] = 8'h01;
		{mem[8'h18], mem[8'h17], mem[8'h16], mem[8'h14], mem[8'h13], mem[8'h12]} =
			{8'h60, 8'h28, 8'he3, 8'h8d, 8'h19, 8'h11};
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		ports();
		rd(8'h00, 25, 1'b1);
		rd(8'h20, 8, 1'b0);
		$display("test reset_map done");
		for (int k = 0; k < 4; k++) begin
			wq = {};
			for (int j = 0; j < 7; j++) wq.push_back(8'(rnd()));
			wr(8'h12, wq);
			// corner: pin surely high while the next pass writes 17h
			pin_sel <= (k == 1) ? 1'b1 : 1'(rnd());
			repeat (2) @(posedge clk);
			ports();
			rd(8'h12, 7, 1'(k % 2));
		end
		$display("test writes done");
		wq = {8'(rnd()), 8'(rnd()), 8'(rnd()), 8'(rnd()), 8'(rnd()), 8'(rnd())};
		wr(8'hfe, wq);
		rd(8'hfe, 8, 1'b1);
		$display("test read_only_wrap done");
		for (int k = 0; k < 6; k++) begin
			st = 8'(rnd());
			status <= st;
			mem[0] = mem[0] | ((mem[1] ^ st) & `BRG_SPARE_MASK);
			mem[1] = st & `BRG_SPARE_MASK;
			repeat (3) @(posedge clk);
			rd(8'h00, 2, 1'(k % 2));
			rd(8'h00, 1, 1'b1);
		end
		$display("test events done");
		foreach (foreign[i]) begin
			brg_host_inst.bus_start();
			addr(foreign[i], 1'b0, 1'b1);
			brg_host_inst.bus_stop();
		end
		rd(8'h16, 3, 1'b0);
		$display("test foreign_address done");
		wrap_up();
	end
	// hang guard, well past the expected run
	initial begin
		repeat (80000) @(posedge clk);
		fail_count++;
		wrap_up();
	end
endmodule : tb
`default_nettype wire
